// ---- pkg/spio_pkg.sv ----
package spio_pkg;

	localparam int PIN_N   = 16;
	localparam int RP_IO_N = 8;
	localparam int RSRC_N  = 4;
	localparam int RIN_N   = 4;
	localparam int OMAP_W  = 6;
	localparam int IMAP_W  = 7;
	localparam int AW      = 5;
	localparam int DW      = 16;

	// pins 0..7 remappable in/out, 8..11 remappable input only
	localparam logic [IMAP_W-1:0] RP_IN_CNT = 7'h0C;
	localparam logic [OMAP_W-1:0] RSRC_CNT  = 6'h04;

	// bonded pins of this variant; the rest read as zero outside analog select and pull enables
	localparam logic [DW-1:0] IMPL_MASK = 16'h3FFF;

	localparam logic [DW-1:0] DIR_RST   = 16'hFFFF;
	localparam logic [DW-1:0] ANALOG_SELECT_BIT_RST = 16'hFFFF;
	localparam logic [DW-1:0] LAT_RST   = 16'h0000;

	localparam logic [AW-1:0] A_DIR    = 5'h00;
	localparam logic [AW-1:0] A_LAT    = 5'h01;
	localparam logic [AW-1:0] A_PORT   = 5'h02;
	localparam logic [AW-1:0] A_ODC    = 5'h03;
	localparam logic [AW-1:0] A_ANALOG_SELECT_BIT  = 5'h04;
	localparam logic [AW-1:0] A_CNEN   = 5'h05;
	localparam logic [AW-1:0] A_CNPU   = 5'h06;
	localparam logic [AW-1:0] A_CNPD   = 5'h07;
	localparam logic [AW-1:0] A_CNSTAT = 5'h08;
	localparam logic [AW-1:0] A_KEY    = 5'h09;
	localparam logic [AW-1:0] A_LOCK   = 5'h0A;
	localparam logic [AW-1:0] A_OMAP0  = 5'h10;
	localparam logic [AW-1:0] A_IMAP0  = 5'h18;

	localparam logic [DW-1:0] KEY_A = 16'h0055;
	localparam logic [DW-1:0] KEY_B = 16'h00AA;

endpackage

// ---- rtl/spio_port.sv ----
// Overview of operation
// - driving peripheral owns pin output over port
// - port output never loops into peripheral input
// - peripheral driving disables port driver, pin readable
// - enabled idle peripheral lets port drive pin
// - direction one is input, zero output
// - reset makes every pin an input
// - latch reads latch; pin reg reads pins, writes latch
// - unimplemented bits read zero except in analog select and pull enables
// - open-drain bit makes pin open-drain
// - analog select resets to all ones
// - analog pins read zero in pin register
// - change on selected pin raises interrupt
// - per-pin change interrupt enable bit
// - separate weak pull-up and pull-down enables
// - pins remap in/out or input only
// - remapped peripheral unconnected until assigned
// - remap beats digital, never analog functions
// - mapping protected against spurious changes
// - separate input and output mapping registers
// - seven-bit field selects each remapped input
// - output map resets to zero, null output
//
// Our own choices: the register addresses and the plain strobed port.
module spio_port (
	input  wire logic                                ref_clk,
	input  wire logic                                resetn,
	input  wire logic [spio_pkg::AW-1:0]             addr,
	input  wire logic [spio_pkg::DW-1:0]             wdata,
	input  wire logic                                wr_stb,
	input  wire logic                                rd_stb,
	output logic      [spio_pkg::DW-1:0]             rdata,
	input  wire logic [spio_pkg::PIN_N-1:0]          pin_in,
	output logic      [spio_pkg::PIN_N-1:0]          pin_out,
	output logic      [spio_pkg::PIN_N-1:0]          pin_oe,
	output logic      [spio_pkg::PIN_N-1:0]          pull_up_en,
	output logic      [spio_pkg::PIN_N-1:0]          pull_down_en,
	output logic      [spio_pkg::PIN_N-1:0]          analog_mode,
	input  wire logic [spio_pkg::PIN_N-1:0]          fix_periph_en,
	input  wire logic [spio_pkg::PIN_N-1:0]          fix_periph_drive,
	input  wire logic [spio_pkg::PIN_N-1:0]          fix_periph_out,
	output logic      [spio_pkg::PIN_N-1:0]          fix_periph_in,
	input  wire logic [spio_pkg::RSRC_N-1:0]         rmp_src_en,
	input  wire logic [spio_pkg::RSRC_N-1:0]         rmp_src_drive,
	input  wire logic [spio_pkg::RSRC_N-1:0]         rmp_src_out,
	output logic      [spio_pkg::RIN_N-1:0]          rmp_periph_in,
	output logic                                     change_irq,
	output logic                                     remap_locked
);

	typedef struct packed {
		logic [spio_pkg::DW-1:0]                          dir;
		logic [spio_pkg::DW-1:0]                          lat;
		logic [spio_pkg::DW-1:0]                          odc;
		logic [spio_pkg::DW-1:0]                          analog_select_bit;
		logic [spio_pkg::DW-1:0]                          cnen;
		logic [spio_pkg::DW-1:0]                          cnpu;
		logic [spio_pkg::DW-1:0]                          cnpd;
		logic [spio_pkg::DW-1:0]                          cn_stat;
		logic [spio_pkg::DW-1:0]                          meta;
		logic [spio_pkg::DW-1:0]                          sync;
		logic [spio_pkg::DW-1:0]                          prev;
		logic                                             key1;
		logic                                             arm;
		logic                                             lock;
		logic [spio_pkg::RP_IO_N-1:0][spio_pkg::OMAP_W-1:0] omap;
		logic [spio_pkg::RIN_N-1:0][spio_pkg::IMAP_W-1:0]   imap;
		logic [spio_pkg::DW-1:0]                          rdata;
		logic [spio_pkg::DW-1:0]                          out;
		logic [spio_pkg::DW-1:0]                          oe;
		logic [spio_pkg::DW-1:0]                          pu;
		logic [spio_pkg::DW-1:0]                          pd;
		logic [spio_pkg::DW-1:0]                          fin;
		logic [spio_pkg::RIN_N-1:0]                       rin;
		logic                                             irq;
	} spio_state_type;

	spio_state_type q;
	spio_state_type d;

	logic [spio_pkg::PIN_N-1:0] rmp_act_v;
	logic [spio_pkg::PIN_N-1:0] per_own_v;
	logic [spio_pkg::PIN_N-1:0] port_drv_v;
	logic [spio_pkg::PIN_N-1:0] nxt_oe_v;
	logic [spio_pkg::PIN_N-1:0] nxt_out_v;
	logic [spio_pkg::PIN_N-1:0] dig_v;
	logic [spio_pkg::PIN_N-1:0] pin_view_v;
	logic [spio_pkg::PIN_N-1:0] chg_v;

	function automatic logic omap_ok(input logic [spio_pkg::OMAP_W-1:0] f);
		omap_ok = (f != 6'h00) && (f <= spio_pkg::RSRC_CNT);
	endfunction

	function automatic logic [1:0] omap_idx(
		input logic [spio_pkg::OMAP_W-1:0] f);
		logic [spio_pkg::OMAP_W-1:0] k;
		k = f - 6'h01;
		omap_idx = k[1:0];
	endfunction

	// code 0 ties the input low; codes past the last pin also read low
	function automatic logic imap_pick(
		input logic [spio_pkg::IMAP_W-1:0] code,
		input logic [spio_pkg::PIN_N-1:0]  lv);
		logic [spio_pkg::IMAP_W-1:0] k;
		k = code - 7'h01;
		imap_pick = 1'b0;
		if (code != 7'h00 && code <= spio_pkg::RP_IN_CNT) begin
			imap_pick = lv[k[3:0]];
		end
	endfunction

	// pins in analog mode present zero to all digital logic
	assign dig_v = q.sync & ~q.analog_select_bit & spio_pkg::IMPL_MASK;

	genvar i;
	generate
		for (i = 0; i < spio_pkg::PIN_N; i++) begin : g_pin
			logic       rmp_drv;
			logic       fix_drv;
			logic       drv_val;
			logic       raw_val;
			if (i < spio_pkg::RP_IO_N) begin : g_rp
				logic [1:0] sx;
				assign sx = omap_idx(q.omap[i]);
				// null code or analog pin keeps the remap off
				assign rmp_act_v[i] = omap_ok(q.omap[i]) & rmp_src_en[sx]
					& ~q.analog_select_bit[i];
				assign rmp_drv = rmp_act_v[i] & rmp_src_drive[sx];
				assign drv_val = rmp_drv ? rmp_src_out[sx]
					: fix_periph_out[i];
			end else begin : g_fix
				assign rmp_act_v[i] = 1'b0;
				assign rmp_drv = 1'b0;
				assign drv_val = fix_periph_out[i];
			end
			// remap outranks the fixed peripheral on the same pin
			assign fix_drv = fix_periph_en[i] & fix_periph_drive[i]
				& ~rmp_act_v[i];
			assign per_own_v[i] = rmp_drv | fix_drv;
			// port drives pins with direction zero when no peripheral is actively driving
			assign port_drv_v[i] = ~per_own_v[i] & ~q.dir[i];
			assign raw_val = per_own_v[i] ? drv_val : q.lat[i];
			// open drain only pulls low, releases for a one
			assign nxt_oe_v[i] = spio_pkg::IMPL_MASK[i]
				& (per_own_v[i] | port_drv_v[i])
				& ~(q.odc[i] & raw_val);
			assign nxt_out_v[i] = raw_val & ~q.odc[i];
		end
	endgenerate

	// peripherals never see the port's own output on the pin
	assign pin_view_v = dig_v & ~port_drv_v;
	// compares against last sample; blind while clocks are stopped
	assign chg_v = (q.sync ^ q.prev) & q.cnen & ~q.analog_select_bit
		& spio_pkg::IMPL_MASK;

	always_comb begin
		d = q;
		d.meta = pin_in;
		d.sync = q.meta;
		d.prev = q.sync;
		d.out = nxt_out_v;
		d.oe = nxt_oe_v;
		d.pu = q.cnpu & spio_pkg::IMPL_MASK;
		d.pd = q.cnpd & spio_pkg::IMPL_MASK;
		d.fin = pin_view_v;
		for (int k = 0; k < spio_pkg::RIN_N; k++) begin
			d.rin[k] = imap_pick(q.imap[k], pin_view_v);
		end
		// a new change wins over a clear in the same cycle
		d.cn_stat = q.cn_stat | chg_v;
		if (wr_stb) begin
			d.key1 = (addr == spio_pkg::A_KEY) && (wdata == spio_pkg::KEY_A);
			d.arm = (addr == spio_pkg::A_KEY) && (wdata == spio_pkg::KEY_B)
				&& q.key1;
			case (addr)
				spio_pkg::A_DIR: begin
					d.dir = wdata & spio_pkg::IMPL_MASK;
				end
				spio_pkg::A_LAT, spio_pkg::A_PORT: begin
					d.lat = wdata & spio_pkg::IMPL_MASK;
				end
				spio_pkg::A_ODC: begin
					d.odc = wdata & spio_pkg::IMPL_MASK;
				end
				spio_pkg::A_ANALOG_SELECT_BIT: begin
					d.analog_select_bit = wdata;
				end
				spio_pkg::A_CNEN: begin
					d.cnen = wdata & spio_pkg::IMPL_MASK;
				end
				spio_pkg::A_CNPU: begin
					d.cnpu = wdata;
				end
				spio_pkg::A_CNPD: begin
					d.cnpd = wdata;
				end
				spio_pkg::A_CNSTAT: begin
					d.cn_stat = (q.cn_stat & ~wdata) | chg_v;
				end
				spio_pkg::A_LOCK: begin
					// lock only moves right after the two-word key
					if (q.arm) begin
						d.lock = wdata[0];
					end
				end
				default: begin
					if (!q.lock && addr[4:3] == 2'b10) begin
						d.omap[addr[2:0]] = wdata[spio_pkg::OMAP_W-1:0];
					end else if (!q.lock && addr[4:2] == 3'b110) begin
						d.imap[addr[1:0]] = wdata[spio_pkg::IMAP_W-1:0];
					end
				end
			endcase
		end
		d.rdata = 16'h0000;
		if (rd_stb) begin
			case (addr)
				spio_pkg::A_DIR:    d.rdata = q.dir;
				spio_pkg::A_LAT:    d.rdata = q.lat;
				spio_pkg::A_PORT:   d.rdata = dig_v;
				spio_pkg::A_ODC:    d.rdata = q.odc;
				spio_pkg::A_ANALOG_SELECT_BIT:  d.rdata = q.analog_select_bit;
				spio_pkg::A_CNEN:   d.rdata = q.cnen;
				spio_pkg::A_CNPU:   d.rdata = q.cnpu;
				spio_pkg::A_CNPD:   d.rdata = q.cnpd;
				spio_pkg::A_CNSTAT: d.rdata = q.cn_stat;
				spio_pkg::A_LOCK:   d.rdata = {15'h0000, q.lock};
				default: begin
					if (addr[4:3] == 2'b10) begin
						d.rdata = {10'h000, q.omap[addr[2:0]]};
					end else if (addr[4:2] == 3'b110) begin
						d.rdata = {9'h000, q.imap[addr[1:0]]};
					end
				end
			endcase
		end
		d.irq = |q.cn_stat;
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			q <= '0;
			q.dir <= spio_pkg::DIR_RST & spio_pkg::IMPL_MASK;
			q.lat <= spio_pkg::LAT_RST;
			q.analog_select_bit <= spio_pkg::ANALOG_SELECT_BIT_RST;
		end else begin
			q <= d;
		end
	end

	assign rdata = q.rdata;
	assign pin_out = q.out;
	assign pin_oe = q.oe;
	assign pull_up_en = q.pu;
	assign pull_down_en = q.pd;
	assign analog_mode = q.analog_select_bit;
	assign fix_periph_in = q.fin;
	assign rmp_periph_in = q.rin;
	assign change_irq = q.irq;
	assign remap_locked = q.lock;

	sequence s_key_pair;
		wr_stb && addr == spio_pkg::A_KEY && wdata == spio_pkg::KEY_A
		##1 wr_stb && addr == spio_pkg::A_KEY && wdata == spio_pkg::KEY_B;
	endsequence

	sequence s_lock_write;
		wr_stb && addr == spio_pkg::A_LOCK;
	endsequence

	a_reset_dir_input: assert property (@(posedge ref_clk)
		!resetn |=> q.dir == (spio_pkg::DIR_RST & spio_pkg::IMPL_MASK))
		else $error("direction not all input after reset");

	a_reset_analog_select_bit_ones: assert property (@(posedge ref_clk)
		!resetn |=> q.analog_select_bit == spio_pkg::ANALOG_SELECT_BIT_RST && q.omap == '0)
		else $error("analog select or output map wrong after reset");

	a_port_write_latch: assert property (@(posedge ref_clk)
		disable iff (!resetn)
		wr_stb && addr == spio_pkg::A_PORT
		|=> q.lat == ($past(wdata) & spio_pkg::IMPL_MASK))
		else $error("pin register write did not reach latch");

	a_analog_read_zero: assert property (@(posedge ref_clk)
		disable iff (!resetn)
		rd_stb && addr == spio_pkg::A_PORT
		|=> (rdata & $past(q.analog_select_bit)) == 16'h0000)
		else $error("analog pin read nonzero");

	a_unimpl_read_zero: assert property (@(posedge ref_clk)
		disable iff (!resetn)
		rd_stb && (addr == spio_pkg::A_DIR || addr == spio_pkg::A_LAT
			|| addr == spio_pkg::A_PORT)
		|=> (rdata & ~spio_pkg::IMPL_MASK) == 16'h0000)
		else $error("unimplemented bit read nonzero");

	a_change_sticky: assert property (@(posedge ref_clk)
		disable iff (!resetn)
		!(wr_stb && addr == spio_pkg::A_CNSTAT)
		|=> (q.cn_stat & $past(q.cn_stat)) == $past(q.cn_stat))
		else $error("pending change lost without clear");

	a_change_irq: assert property (@(posedge ref_clk)
		disable iff (!resetn)
		chg_v != 16'h0000 |=> ##1 change_irq)
		else $error("change did not raise interrupt");

	a_remap_locked: assert property (@(posedge ref_clk)
		disable iff (!resetn)
		q.lock && wr_stb |=> $stable(q.omap) && $stable(q.imap))
		else $error("mapping changed while locked");

	a_lock_after_key: assert property (@(posedge ref_clk)
		disable iff (!resetn)
		s_key_pair ##1 s_lock_write ##0 wdata[0] |=> q.lock)
		else $error("keyed lock write ignored");

	a_input_no_drive: assert property (@(posedge ref_clk)
		disable iff (!resetn)
		1'b1 |=> (pin_oe & $past(q.dir & ~per_own_v)) == 16'h0000)
		else $error("input pin driven by port");

	a_periph_owns: assert property (@(posedge ref_clk)
		disable iff (!resetn)
		1'b1 |=> (pin_oe & $past(per_own_v & ~q.odc
			& spio_pkg::IMPL_MASK)) == $past(per_own_v & ~q.odc
			& spio_pkg::IMPL_MASK))
		else $error("peripheral drive not on pin");

	a_no_loop_through: assert property (@(posedge ref_clk)
		disable iff (!resetn)
		1'b1 |=> (fix_periph_in & $past(port_drv_v)) == 16'h0000)
		else $error("port output looped into peripheral");

endmodule

// ---- tb/spio_pin_model.sv ----
module spio_pin_model (
	input  wire logic        ref_clk,
	input  wire logic [15:0] pin_out,
	input  wire logic [15:0] pin_oe,
	input  wire logic [15:0] pull_up_en,
	input  wire logic [15:0] pull_down_en,
	input  wire logic [15:0] ext_en,
	input  wire logic [15:0] ext_val,
	output logic      [15:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] churn = 16'h5A5A;
	// floating pins wander so no stale level passes as real
	always @(posedge ref_clk) churn <= ~churn;
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_val[i];
			else if (pull_up_en[i] | pull_down_en[i])
				pin_in[i] = pull_up_en[i];
			else
				pin_in[i] = churn[i];
		end
	end
endmodule

// ---- tb/tb_top.sv ----
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] M = spio_pkg::IMPL_MASK;
	logic        ref_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [4:0]  addr = 5'h00;
	logic [15:0] wdata = 16'h0000;
	logic        wr_stb = 1'b0;
	logic        rd_stb = 1'b0;
	logic [15:0] rdata, pin_in, pin_out, pin_oe, pull_up_en, pull_down_en;
	logic [15:0] analog_mode, fix_periph_in, ext_val = 16'h0000;
	logic [15:0] fix_periph_en = 16'h0000, fix_periph_drive = 16'h0000;
	logic [15:0] fix_periph_out = 16'h0000, ext_en = 16'hFFFF;
	logic [3:0]  rmp_src_en = 4'hF, rmp_src_drive = 4'hF;
	logic [3:0]  rmp_src_out = 4'h0, rmp_periph_in, e_rin;
	logic        change_irq, remap_locked, m_lock = 1'b0;
	logic [15:0] rnd = 16'h0048, m_dir = M, m_lat = 16'h0000;
	logic [15:0] m_odc = 16'h0000, m_analog_select_bit = 16'hFFFF, m_lvl, m_view;
	int          m_omap[8] = '{default: 0}, m_imap[4] = '{default: 0};
	int          ks = 0, n_mismatch = 0, checked = 0;

	always #5 ref_clk = ~ref_clk;

	spio_port spio_port_i (
		.ref_clk, .resetn, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
		.pin_in, .pin_out, .pin_oe, .pull_up_en, .pull_down_en,
		.analog_mode, .fix_periph_en, .fix_periph_drive, .fix_periph_out,
		.fix_periph_in, .rmp_src_en, .rmp_src_drive, .rmp_src_out,
		.rmp_periph_in, .change_irq, .remap_locked
	);
	spio_pin_model spio_pin_model_i (
		.ref_clk, .pin_out, .pin_oe, .pull_up_en, .pull_down_en,
		.ext_en, .ext_val, .pin_in
	);

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input string nm, input logic [15:0] e,
			input logic [15:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic close_out();
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// the idle cycle after each strobe also keeps writes apart from reads
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
		if (a == spio_pkg::A_DIR) m_dir = d & M;
		if (a == spio_pkg::A_LAT || a == spio_pkg::A_PORT) m_lat = d;
		if (a == spio_pkg::A_ODC) m_odc = d;
		if (a == spio_pkg::A_ANALOG_SELECT_BIT) m_analog_select_bit = d;
		if (a >= 5'h10 && a < 5'h18 && !m_lock) m_omap[a - 16] = d[5:0];
		if (a >= 5'h18 && a < 5'h1C && !m_lock) m_imap[a - 24] = d[6:0];
		if (a == spio_pkg::A_LOCK && ks == 2) m_lock = d[0];
		ks = (a == spio_pkg::A_KEY && d == spio_pkg::KEY_A) ? 1 :
			(a == spio_pkg::A_KEY && d == spio_pkg::KEY_B && ks == 1) ? 2 : 0;
	endtask

	// key pair and lock write with no gap, as a master may issue them
	task automatic wr_key_lock(input logic [15:0] d);
		@(posedge ref_clk);
		addr <= spio_pkg::A_KEY;
		wdata <= spio_pkg::KEY_A;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wdata <= spio_pkg::KEY_B;
		@(posedge ref_clk);
		addr <= spio_pkg::A_LOCK;
		wdata <= d;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
		m_lock = d[0];
		ks = 0;
	endtask

	task automatic rchk(input string nm, input logic [4:0] a,
			input logic [15:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1 chk(nm, e, rdata);
	endtask

	task automatic pins_chk();
		int k;
		logic act;
		logic [15:0] drv, val, pdrv, eoe;
		drv = 16'h0000;
		val = 16'h0000;
		pdrv = 16'h0000;
		repeat (6) @(posedge ref_clk);
		#1;
		for (int i = 0; i < 16; i++) begin
			k = (i < 8) ? m_omap[i] - 1 : -1;
			// an active remap shuts out the fixed peripheral even when idle
			act = k >= 0 && k < 4 && rmp_src_en[k] && !m_analog_select_bit[i];
			if (act && rmp_src_drive[k]) begin
				drv[i] = 1'b1;
				val[i] = rmp_src_out[k];
			end else if (!act && fix_periph_en[i] &&
					fix_periph_drive[i]) begin
				drv[i] = 1'b1;
				val[i] = fix_periph_out[i];
			end else if (!m_dir[i]) begin
				drv[i] = 1'b1;
				val[i] = m_lat[i];
				pdrv[i] = 1'b1;
			end
		end
		drv = drv & M;
		pdrv = pdrv & M;
		eoe = (drv & ~m_odc) | (drv & m_odc & ~val);
		chk("pin_oe", eoe, pin_oe);
		chk("pin_out", val & ~m_odc & eoe, pin_out & eoe);
		m_lvl = (eoe & val & ~m_odc) | (~eoe & ext_val);
		m_view = m_lvl & M & ~m_analog_select_bit & ~pdrv;
		chk("fix_periph_in", m_view, fix_periph_in);
		for (int j = 0; j < 4; j++)
			e_rin[j] = (m_imap[j] >= 1 && m_imap[j] <= 12) ?
				m_view[m_imap[j] - 1] : 1'b0;
		chk("rmp_periph_in", 16'(e_rin), 16'(rmp_periph_in));
		rchk("pin_level", spio_pkg::A_PORT, m_lvl & M & ~m_analog_select_bit);
	endtask

	task automatic wait_irq();
		for (int t = 0; t < 10 && change_irq !== 1'b1; t++) begin
			@(posedge ref_clk);
			#1;
		end
		chk("change_irq", 16'h0001, 16'(change_irq));
		if (change_irq !== 1'b1) close_out();
	endtask

	initial begin
		repeat (90000) @(posedge ref_clk);
		n_mismatch++;
		close_out();
	end

	initial begin
		repeat (8) @(posedge ref_clk);
		resetn <= 1'b1;
		rchk("dir", spio_pkg::A_DIR, M);
		rchk("lat", spio_pkg::A_LAT, 16'h0000);
		rchk("analog_select_bit", spio_pkg::A_ANALOG_SELECT_BIT, 16'hFFFF);
		chk("analog_mode", 16'hFFFF, analog_mode);
		pins_chk();
		rchk("unmapped", 5'h0C, 16'h0000);
		wr(spio_pkg::A_ANALOG_SELECT_BIT, 16'h0000);
		wr(spio_pkg::A_LOCK, 16'h0001);
		#1 chk("locked", 16'h0000, 16'(remap_locked));
		for (int n = 0; n < 12; n++) begin
			rnd = lfsr(rnd);
			wr(spio_pkg::A_DIR, rnd | 16'hF000 | (n > 7 ? 16'h00F0 : 16'h0000));
			rnd = lfsr(rnd);
			wr(n[0] ? spio_pkg::A_PORT : spio_pkg::A_LAT, rnd);
			rnd = lfsr(rnd);
			wr(spio_pkg::A_ODC, n > 5 ? rnd : 16'h0000);
			wr(spio_pkg::A_OMAP0 + 5'(n[2:0]), 16'(rnd[2:0]));
			wr(spio_pkg::A_IMAP0 + 5'(n[1:0]), 16'(rnd[7:4]));
			if (n == 8) wr(spio_pkg::A_ANALOG_SELECT_BIT, 16'h00F0);
			@(posedge ref_clk);
			rnd = lfsr(rnd);
			fix_periph_en <= rnd & 16'h0FFF;
			fix_periph_out <= ~rnd;
			rmp_src_en <= rnd[3:0];
			rnd = lfsr(rnd);
			fix_periph_drive <= rnd;
			rmp_src_drive <= rnd[7:4];
			rmp_src_out <= rnd[11:8];
			ext_val <= rnd ^ 16'hA5A5;
			pins_chk();
			rchk("lat", spio_pkg::A_LAT, m_lat & M);
		end
		@(posedge ref_clk);
		rmp_src_en <= 4'hF;
		rmp_src_drive <= 4'hF;
		rmp_src_out <= 4'h4;
		wr(spio_pkg::A_ANALOG_SELECT_BIT, 16'h0000);
		wr(spio_pkg::A_OMAP0, 16'h0003);
		wr_key_lock(16'h0001);
		#1 chk("locked", 16'h0001, 16'(remap_locked));
		wr(spio_pkg::A_OMAP0, 16'h0001);
		wr(spio_pkg::A_IMAP0, 16'h0002);
		pins_chk();
		// peripherals off so the watched pins follow the outside level
		@(posedge ref_clk);
		fix_periph_en <= 16'h0000;
		rmp_src_en <= 4'h0;
		// all inputs first so the port no longer drives the watched pins
		wr(spio_pkg::A_DIR, 16'hFFFF);
		wr(spio_pkg::A_CNEN, 16'h0008);
		// let the ownership change pass the synchroniser before clearing
		repeat (6) @(posedge ref_clk);
		wr(spio_pkg::A_CNSTAT, 16'hFFFF);
		@(posedge ref_clk);
		ext_val <= ext_val ^ 16'h0010;
		repeat (6) @(posedge ref_clk);
		#1 chk("change_irq", 16'h0000, 16'(change_irq));
		@(posedge ref_clk);
		ext_val <= ext_val ^ 16'h0008;
		wait_irq();
		repeat (5) @(posedge ref_clk);
		#1 chk("change_irq", 16'h0001, 16'(change_irq));
		rchk("cnstat", spio_pkg::A_CNSTAT, 16'h0008);
		wr(spio_pkg::A_CNSTAT, 16'h0008);
		wr(spio_pkg::A_ANALOG_SELECT_BIT, 16'h0008);
		@(posedge ref_clk);
		ext_val <= ext_val ^ 16'h0008;
		repeat (6) @(posedge ref_clk);
		#1 chk("change_irq", 16'h0000, 16'(change_irq));
		wr(spio_pkg::A_CNPU, 16'hF00F);
		wr(spio_pkg::A_CNPD, 16'h0FF0);
		repeat (2) @(posedge ref_clk);
		#1 chk("pull_up_en", 16'hF00F & M, pull_up_en);
		chk("pull_down_en", 16'h0FF0 & M, pull_down_en);
		close_out();
	end
endmodule
